// *** core/bitband_map.svh ***
// Address map and field constants of the bit-band alias remapper.
`ifndef BITBAND_MAP_SVH
`define BITBAND_MAP_SVH
`define SRAM_BAND_BASE 32'h2000_0000
`define SRAM_DIRECT_END 32'h2000_FFFF
`define SRAM_ALIAS_BASE 32'h2200_0000
`define SRAM_ALIAS_END 32'h221F_FFFF
`define PERI_BAND_BASE 32'h4000_0000
`define PERI_BAND_END 32'h400F_FFFF
`define PERI_ALIAS_BASE 32'h4200_0000
`define PERI_ALIAS_END 32'h43FF_FFFF
`define BAND_SPAN_BITS 20
`define ALIAS_SPAN_BITS 25
`define BYTE_SHIFT 5
`define BIT_SHIFT 2
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`endif

// *** core/bitband_pkg.sv ***
// Types shared by the bit-band alias remapper.
package bitband_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_rd = 3'h1,
    st_wr = 3'h3,
    st_done = 3'h2,
    st_direct = 3'h6
  } state_t;
endpackage : bitband_pkg

// *** core/bitband_remap.sv ***
// Bit-band alias remapper between the core data bus and the memory fabric.
// How it works
// - Bit-band regions are the lowest 64 KB of SRAM and the lowest 1 MB of peripheral space.
// - The 2 MB SRAM alias space maps onto its 64 KB bit-band space, the 32 MB peripheral one onto 1 MB.
// - Direct SRAM band addresses pass through as ordinary SRAM accesses.
// - SRAM alias data accesses remap; instruction fetches there pass unchanged.
// - Direct peripheral band addresses pass through as ordinary peripheral accesses.
// - Peripheral alias data accesses remap; instruction fetches there get an error.
// - Alias writes read the location, change one bit, write it back.
// - The underlying access keeps the original byte, halfword or word size.
// - Alias offset is byte offset times 32 plus bit number times 4.
// - Bit position 0 to 7 within the byte comes from the alias offset.
// - Write data bit 0 sets or clears the targeted bit.
// - Write data bits 31 to 1 are ignored.
// - Alias reads return 0 or 1 in bit 0.
// - Byte lanes are little-endian, lowest address in lowest lane.
`timescale 1ns/1ns
`include "bitband_map.svh"
module bitband_remap (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Core side request
  input wire logic core_req,
  input wire logic core_write,
  input wire logic core_instr,
  input wire logic [1:0] core_size,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_wdata,
  // Core side answer
  output logic core_done,
  output logic core_err,
  output logic [31:0] core_rdata,
  // Fabric side request
  output logic mem_req,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  // Fabric side answer
  input wire logic mem_done,
  input wire logic [31:0] mem_rdata
);
  // The state codes step one bit at a time along idle, read, write, done and back.
  bitband_pkg::state_t state;
  logic [4:0] bit_lane;
  logic held_write;
  logic held_bit;

  // A request is taken in st_idle and answered with core_done one cycle after the
  // last fabric answer. An alias read costs one fabric read. An alias write costs a
  // read and a write that follows it at once, so no other access of this master can
  // fall between the two halves and see or spoil the half-finished byte.
  // A direct access costs one fabric access of either kind.
  // The fabric answers with a one-cycle mem_done, and mem_req stays up until then.
  // A refused fetch from the peripheral alias space never reaches the fabric.
  // Only one request is in flight; the core must hold its request until core_done.
  // Other masters on the fabric are not locked out between the two halves; a user
  // who shares a target with another master must arbitrate that outside.

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Alias word address to underlying byte address; the bit inside the word lanes comes from lane_of.
  function automatic logic [31:0] band_addr(input logic [31:0] a, input logic [31:0] abase,
                                            input logic [31:0] bbase);
    logic [31:0] off;
    off = a - abase;
    // Each byte owns 32 alias bytes, so the byte offset is the alias offset over 32.
    // The bit-number field below that is taken apart separately by lane_of.
    band_addr = bbase + {12'h000, off[`ALIAS_SPAN_BITS-1:`BYTE_SHIFT]};
  endfunction : band_addr

  // The underlying access is aligned to its size; the bit lane counts from that base.
  function automatic logic [31:0] aligned(input logic [31:0] a, input logic [1:0] sz);
    if (sz == `SIZE_WORD) begin
      aligned = {a[31:2], 2'h0};
    end else if (sz == `SIZE_HALF) begin
      aligned = {a[31:1], 1'h0};
    end else begin
      aligned = a;
    end
  endfunction : aligned

  // Byte of the underlying access that holds the bit, counted from the aligned base.
  // A byte access has one lane, a halfword two and a word four; the lane then
  // picks the bit inside that little-endian data word.
  function automatic logic [4:0] lane_of(input logic [31:0] ba, input logic [1:0] sz,
                                         input logic [2:0] bitno);
    logic [1:0] ofs;
    if (sz == `SIZE_WORD) begin
      ofs = ba[1:0];
    end else if (sz == `SIZE_HALF) begin
      ofs = {1'b0, ba[0]};
    end else begin
      ofs = 2'h0;
    end
    lane_of = {ofs, bitno};
  endfunction : lane_of

  // Old word with one bit replaced; every other lane goes back exactly as it was read.
  function automatic logic [31:0] merge_bit(input logic [31:0] old, input logic [4:0] ln,
                                            input logic val);
    merge_bit = old;
    merge_bit[ln] = val;
  endfunction : merge_bit

  logic sram_alias;
  logic peri_alias;
  logic any_alias;
  logic refused;
  logic [31:0] byte_addr;
  logic [4:0] lane;
  always_comb begin
    sram_alias = in_range(core_addr, `SRAM_ALIAS_BASE, `SRAM_ALIAS_END) && !core_instr;
    peri_alias = in_range(core_addr, `PERI_ALIAS_BASE, `PERI_ALIAS_END);
    any_alias = sram_alias || peri_alias;
    // Fetches from the peripheral alias space are refused outright.
    refused = peri_alias && core_instr;
    if (sram_alias) begin
      byte_addr = band_addr(core_addr, `SRAM_ALIAS_BASE, `SRAM_BAND_BASE);
    end else begin
      byte_addr = band_addr(core_addr, `PERI_ALIAS_BASE, `PERI_BAND_BASE);
    end
    // Little-endian: byte k of the access sits in lanes 8k+7..8k.
    lane = lane_of(byte_addr, core_size, core_addr[4:2]);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= bitband_pkg::st_idle;
    end else if (ce) begin
      case (state)
        bitband_pkg::st_idle: begin
          if (core_req) begin
            if (refused) begin
              state <= bitband_pkg::st_done;
            end else if (any_alias) begin
              state <= bitband_pkg::st_rd;
            end else begin
              state <= bitband_pkg::st_direct;
            end
          end
        end
        bitband_pkg::st_direct: begin
          if (mem_done) begin
            state <= bitband_pkg::st_done;
          end
        end
        bitband_pkg::st_rd: begin
          if (mem_done) begin
            // The write half follows at once so nothing from here slips between.
            state <= held_write ? bitband_pkg::st_wr : bitband_pkg::st_done;
          end
        end
        bitband_pkg::st_wr: begin
          if (mem_done) begin
            state <= bitband_pkg::st_done;
          end
        end
        default: begin
          state <= bitband_pkg::st_idle;
        end
      endcase
    end
  end

  // Capture of the request. The fabric address comes from a flip-flop so that the
  // address adder does not sit in the same cycle as the fabric decode.
  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_lane <= 5'h00;
      held_write <= 1'b0;
      held_bit <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_size <= 2'h0;
    end else if (ce && state == bitband_pkg::st_idle && core_req) begin
      bit_lane <= lane;
      held_write <= core_write;
      // Only bit 0 of the write data matters for an alias write.
      held_bit <= core_wdata[0];
      mem_size <= core_size;
      mem_addr <= any_alias ? aligned(byte_addr, core_size) : core_addr;
    end
  end

  // Read data: alias reads return the single bit, error answers return zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_rdata <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      core_err <= 1'b0;
    end else if (ce) begin
      if (state == bitband_pkg::st_idle && core_req) begin
        core_err <= refused;
        core_rdata <= 32'h0000_0000;
        mem_wdata <= core_wdata;
      end else if (mem_done && state == bitband_pkg::st_direct) begin
        core_rdata <= mem_rdata;
      end else if (mem_done && state == bitband_pkg::st_rd) begin
        core_rdata <= {31'h0, mem_rdata[bit_lane]};
        // The merged word is ready for the write half in the very next cycle.
        mem_wdata <= merge_bit(mem_rdata, bit_lane, held_bit);
      end
    end
  end

  // Handshake outputs follow the state register. The answer to the core is gated by
  // the enable so that a frozen block never shows a pulse that lasts longer than
  // one enabled cycle; the fabric request simply holds while frozen.
  always_comb begin
    mem_req = (state == bitband_pkg::st_direct) || (state == bitband_pkg::st_rd)
              || (state == bitband_pkg::st_wr);
    mem_write = (state == bitband_pkg::st_wr) || ((state == bitband_pkg::st_direct) && held_write);
    core_done = (state == bitband_pkg::st_done) && ce;
  end
endmodule : bitband_remap

// *** sim/bitband_remap_checker.sv ***
// Checker of the bit-band alias remapper port behaviour.
`timescale 1ns/1ns
module bitband_remap_checker (
  input wire logic mclk, rst, core_req, core_write, core_instr, core_done, core_err,
  input wire logic mem_req, mem_write, mem_done,
  input wire logic [1:0] core_size, mem_size,
  input wire logic [31:0] core_addr, core_wdata, core_rdata, mem_addr, mem_wdata, mem_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic pa = core_addr[31:25] == 7'h21;
  wire logic al = !core_instr && (pa || core_addr[31:21] == 11'h110);
  wire logic [4:0] ln = core_addr[6:2] & {core_size[1], core_size != 2'h0, 3'h7};
  wire logic [31:0] sm = {{16{core_size[1]}}, {8{core_size != 2'h0}}, 8'hFF};
  logic [31:0] rq;
  // Keeps the read half so the write half can be judged against it.
  always_ff @(posedge mclk) begin
    if (mem_done && !mem_write) begin
      rq <= mem_rdata;
    end
  end
  property p_rd; core_done && al && !core_write |-> core_rdata == {31'h0, rq[ln]}; endproperty
  a_rd: assert property (p_rd) else $error("alias read value wrong");
  property p_err; core_done && core_instr && pa |-> core_err; endproperty
  a_err: assert property (p_err) else $error("alias fetch not refused");
  property p_size; mem_req |-> mem_size == core_size; endproperty
  a_size: assert property (p_size) else $error("access size changed");
  property p_band; mem_req && al |-> mem_addr == {core_addr[31:28], 8'h0, core_addr[24:7], 2'h0}
    | (mem_addr & 32'h3); endproperty
  a_band: assert property (p_band) else $error("band address wrong");
  property p_direct; mem_req && !al |-> mem_addr == core_addr; endproperty
  a_direct: assert property (p_direct) else $error("direct address altered");
  property p_rmw; mem_done && !mem_write && al && core_write |=> mem_req && mem_write; endproperty
  a_rmw: assert property (p_rmw) else $error("write half not back to back");
  property p_wbit; mem_req && mem_write && al |-> mem_wdata[ln] == core_wdata[0]; endproperty
  a_wbit: assert property (p_wbit) else $error("target bit wrong");
  property p_keep; mem_req && mem_write && al |-> ((mem_wdata ^ rq) & sm & ~(32'h1 << ln)) == 0;
  endproperty
  a_keep: assert property (p_keep) else $error("other bits disturbed");
  c_wr: cover property (core_done && al && core_write);
  c_rd: cover property (core_done && al && !core_write);
  c_err: cover property (core_done && core_err);
endmodule : bitband_remap_checker
bind bitband_remap bitband_remap_checker chk_i (.mclk, .rst, .core_req, .core_write, .core_instr,
  .core_done, .core_err, .mem_req, .mem_write, .mem_done, .core_size, .mem_size, .core_addr,
  .core_wdata, .core_rdata, .mem_addr, .mem_wdata, .mem_rdata);

// *** sim/bitband_mem_model.sv ***
// Memory fabric model answering the remapper after a chosen latency.
`timescale 1ns/1ns
module bitband_mem_model (
  input wire logic mclk, mem_req, mem_write,
  input wire logic [1:0] mem_size, lat,
  input wire logic [31:0] mem_addr, mem_wdata,
  output logic mem_done = 1'b0,
  output logic [31:0] mem_rdata = 32'h0
);
  logic [7:0] mb [0:255];
  logic [1:0] cnt = 2'h0;
  initial foreach (mb[i]) mb[i] = 8'(i * 37);
  // Idle read data toggles so a stale value never passes for an answer.
  always @(posedge mclk) begin
    mem_done <= 1'b0;
    mem_rdata <= ~mem_rdata;
    cnt <= (mem_req && !mem_done) ? cnt + 2'h1 : 2'h0;
    if (mem_req && !mem_done && cnt == lat) begin
      cnt <= 2'h0;
      mem_done <= 1'b1;
      for (int b = 0; b < (1 << mem_size); b++) begin
        mem_rdata[8 * b +: 8] <= mb[mem_addr[7:0] + 8'(b)];
        if (mem_write) mb[mem_addr[7:0] + 8'(b)] <= mem_wdata[8 * b +: 8];
      end
    end
  end
endmodule : bitband_mem_model

// *** sim/bit_band_alias_remapper_tb_top.sv ***
// Testbench of the bit-band alias remapper.
`timescale 1ns/1ns
module bit_band_alias_remapper_tb_top;
  logic mclk = 1'b0, rst = 1'b1, core_req = 1'b0, core_write = 1'b0, core_instr = 1'b0, er;
  logic core_done, core_err, mem_req, mem_write, mem_done;
  logic [1:0] core_size = 2'h2, mem_size, lat = 2'h0;
  logic [31:0] core_addr = 32'h0, core_wdata = 32'h0, core_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic [7:0] sh [0:255];
  int n_fail = 0, total_checks = 0;
  always #5 mclk = ~mclk;
  bitband_remap uut (.mclk, .rst, .ce(1'b1), .core_req, .core_write, .core_instr, .core_size,
    .core_addr, .core_wdata, .core_done, .core_err, .core_rdata, .mem_req, .mem_write, .mem_size,
    .mem_addr, .mem_wdata, .mem_done, .mem_rdata);
  bitband_mem_model fab (.mclk, .mem_req, .mem_write, .mem_size, .lat, .mem_addr, .mem_wdata,
    .mem_done, .mem_rdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic op(input logic w, i, input logic [1:0] s, input logic [31:0] a, d);
    @(negedge mclk);
    {core_req, core_write, core_instr, core_size, core_addr, core_wdata} = {1'b1, w, i, s, a, d};
    lat = 2'($urandom);
    repeat (40) begin
      @(negedge mclk);
      if (core_done === 1'b1) break;
    end
    chk({31'h0, core_done}, 32'h1);
    rd = core_rdata;
    er = core_err;
    core_req = 1'b0;
  endtask : op
  function automatic logic [31:0] wrd(input logic [31:0] a);
    return {sh[a[7:0] + 8'h3], sh[a[7:0] + 8'h2], sh[a[7:0] + 8'h1], sh[a[7:0]]};
  endfunction : wrd
  initial begin
    logic [31:0] a, d;
    void'($urandom(32'hB353));
    foreach (sh[j]) sh[j] = 8'(j * 37);
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    for (int k = 0; k < 40; k++) begin
      a = (k[0] ? 32'h4200_0000 : 32'h2200_0000) | (k < 4 ? 32'h1C : $urandom & 32'h1F_FFFC);
      d = k < 4 ? {28'h0, 4'(32'hE0F1 >> (4 * k))} : $urandom;
      op(1'b1, 1'b0, 2'($urandom % 3), a, d);
      sh[a[12:5]][a[4:2]] = d[0];
      op(1'b0, 1'b0, 2'($urandom % 3), a, 32'h0);
      chk(rd, {31'h0, sh[a[12:5]][a[4:2]]});
      op(1'b0, 1'b0, 2'h2, {a[31:28], 20'h0, a[12:7], 2'h0}, 32'h0);
      chk(rd, wrd({24'h0, a[12:7], 2'h0}));
      op(1'b0, 1'b1, 2'h2, a, 32'h0);
      chk({31'h0, er}, {31'h0, k[0]});
      if (!k[0]) chk(rd, wrd(a));
    end
    wrap_up();
  end
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule : bit_band_alias_remapper_tb_top
